// *** hw/sms_pkg.sv ***
/*
  shared constants and carriers for the servo enable / mode select block.
  assumes a 50 MHz pclk and an apb master with 32-bit data.
*/
package sms_pkg;

  localparam int unsigned CLK_MHZ         = 50;
  localparam int unsigned RATE_WIN_US     = 1000;
  localparam int unsigned RATE_WIN_CYCLES = RATE_WIN_US * CLK_MHZ;

  localparam int unsigned ADDR_W = 8;
  localparam int unsigned SPD_W  = 16;

  localparam logic [7:0] OFF_CTRL    = 8'h00;
  localparam logic [7:0] OFF_STATUS  = 8'h04;
  localparam logic [7:0] OFF_PRESET0 = 8'h08;
  localparam logic [7:0] OFF_POS     = 8'h14;
  localparam logic [7:0] OFF_RATE    = 8'h18;

  localparam int unsigned CTRL_SRC_BIT  = 0;
  localparam int unsigned CTRL_DIR_BIT  = 1;
  localparam int unsigned CTRL_MODE_LSB = 2;
  localparam int unsigned CTRL_PIN_LSB  = 6;
  localparam int unsigned ST_SEQ_BIT    = 8;

  localparam logic [3:0] MODE_SPEED   = 4'h0;
  localparam logic [3:0] MODE_POS     = 4'h1;
  localparam logic [3:0] MODE_TORQUE  = 4'h2;
  localparam logic [3:0] MODE_CONTACT = 4'h3;

  typedef enum logic [1:0]
  {
    SMS_M_SPEED   = 2'b00,
    SMS_M_POS     = 2'b01,
    SMS_M_TORQUE  = 2'b10,
    SMS_M_CONTACT = 2'b11
  } sms_method_type;

  typedef enum logic [1:0]
  {
    SMS_EN_OFF   = 2'b00,
    SMS_EN_READY = 2'b01,
    SMS_EN_RUN   = 2'b11
  } sms_en_state_type;

  typedef struct packed {
    logic [ADDR_W-1:0] paddr;
    logic              pwrite;
    logic [31:0]       pwdata;
    logic              psel;
    logic              penable;
  } sms_apb_req_type;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } sms_apb_rsp_type;

endpackage

// *** hw/sms_dir_map.sv ***
/*
  direction reversal and overtravel steering, purely combinational.
  assumes limit inputs high mean overtravel; registered by the caller.
*/
`timescale 1ns/10ps
module sms_dir_map
(
  input  logic reverse,
  input  logic cmd_forward,
  input  logic fwd_limit,
  input  logic rev_limit,
  output logic turn_cw,
  output logic cw_ok,
  output logic ccw_ok
);
  import sms_pkg::*;

  always_comb
  begin
    // logical forward is ccw normally, cw when reversed
    turn_cw = cmd_forward ? reverse : ~reverse;
    // the limit guarding logical forward moves with it
    if (reverse)
    begin
      cw_ok  = ~fwd_limit;
      ccw_ok = ~rev_limit;
    end
    else
    begin
      cw_ok  = ~rev_limit;
      ccw_ok = ~fwd_limit;
    end
  end

endmodule

// *** hw/sms_pulse_meter.sv ***
/*
  reference pulse counter and pulse rate meter.
  assumes one-cycle pulse strobes synchronous to clk.
*/
`timescale 1ns/10ps
module sms_pulse_meter
#(
  parameter int unsigned POS_W   = 32,
  parameter int unsigned RATE_W  = 16,
  parameter int unsigned WIN_CYC = 50000
)
(
  input  logic              clk,
  input  logic              rst_n,
  input  logic              count_en,
  input  logic              pulse,
  input  logic              pulse_dir,
  output logic [POS_W-1:0]  position,
  output logic [RATE_W-1:0] rate
);
  import sms_pkg::*;

  if (POS_W < 8 || POS_W > 32 || RATE_W < 4 || RATE_W > 32 || WIN_CYC < 2)
  begin : g_bad
    $error("sms_pulse_meter: unsupported parameter values");
  end

  typedef struct packed {
    logic [POS_W-1:0]  pos;
    logic [RATE_W-1:0] acc;
    logic [RATE_W-1:0] rate;
    logic [31:0]       div;
  } sms_meter_state_type;

  sms_meter_state_type s_reg;
  sms_meter_state_type s_next;

  always_comb
  begin
    s_next = s_reg;
    // position follows the count of accepted pulses
    if (count_en && pulse)
    begin
      s_next.pos = pulse_dir ? s_reg.pos - 1'b1 : s_reg.pos + 1'b1;
    end
    if (count_en && pulse && s_reg.acc != {RATE_W{1'b1}})
    begin
      s_next.acc = s_reg.acc + 1'b1;
    end
    // window tick: pulses per window give the speed command
    if (s_reg.div == 32'(WIN_CYC - 1))
    begin
      s_next.div  = '0;
      s_next.rate = s_next.acc;
      s_next.acc  = '0;
    end
    else
    begin
      s_next.div = s_reg.div + 32'h1;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s_reg <= '0;
    end
    else
    begin
      s_reg <= s_next;
    end
  end

  assign position = s_reg.pos;
  assign rate     = s_reg.rate;

endmodule

// *** hw/sms_top.sv ***
/*
  control mode selection, servo enable gating and direction reversal,
  with an apb register file.
  assumes synchronous inputs, a 50 MHz pclk and an apb master.
*/
// Implementation choices: the register addresses and the APB interface to the registers.
`timescale 1ns/10ps
// Functional notes
// - mode digit 0 gives analog speed, 1 pulse position, 2 analog torque.
// - in pulse mode position is the pulse count and speed the pulse rate.
// - mode 3 picks one of three preset speeds from two contact inputs.
// - modes 4 to E switch between pairs of the four basic methods.
// - a low enable input powers the motor, a high one removes power.
// - a setting chooses which input pin carries the enable signal.
// - source bit 0 uses the enable pin, 1 runs once the drive is ready.
// - source and direction changes apply only after a full power cycle.
// - direction bit 0 makes forward ccw, 1 makes forward cw.
// - encoder division outputs keep their polarity when reversed.
// - reversal swaps which limit input guards which physical direction.
// - a high limit input stops motion its way but allows the other way.
module sms_top
#(
  parameter int unsigned POS_W        = 32,
  parameter int unsigned RATE_W       = 16,
  parameter int unsigned EN_PINS      = 4,
  parameter int unsigned RATE_WIN_CYC = sms_pkg::RATE_WIN_CYCLES
)
(
  input  logic                      pclk,
  input  logic                      presetn,
  input  sms_pkg::sms_apb_req_type  apb_req,
  output sms_pkg::sms_apb_rsp_type  apb_rsp,
  input  logic                      main_power_ok,
  input  logic                      ctrl_power_ok,
  input  logic [EN_PINS-1:0]        enable_pins_n,
  input  logic                      ref_active,
  input  logic                      ref_pulse,
  input  logic                      ref_pulse_dir,
  input  logic                      mode_switch_in,
  input  logic                      cmd_forward,
  input  logic                      preset_select_a_n,
  input  logic                      preset_select_b_n,
  input  logic                      preset_select_c_n,
  input  logic                      forward_limit_in,
  input  logic                      reverse_limit_in,
  input  logic                      encoder_a_in,
  input  logic                      encoder_b_in,
  output logic                      servo_ready,
  output logic                      motor_power_en,
  output sms_pkg::sms_method_type   active_method,
  output logic [sms_pkg::SPD_W-1:0] preset_speed,
  output logic                      motor_turn_cw,
  output logic                      cw_permit,
  output logic                      ccw_permit,
  output logic                      encoder_div_phase_a,
  output logic                      encoder_div_phase_b
);
  import sms_pkg::*;

  if (EN_PINS < 1 || EN_PINS > 4)
  begin : g_bad
    $error("sms_top: EN_PINS must be 1 to 4");
  end

  typedef struct packed {
    sms_apb_rsp_type        rsp;
    logic                   src_pend;
    logic                   dir_pend;
    logic [3:0]             mode;
    logic [1:0]             pin_sel;
    logic [2:0][SPD_W-1:0]  presets;
    logic                   src_act;
    logic                   dir_act;
    logic                   main_down;
    logic                   ctrl_down;
    sms_en_state_type       en_state;
    logic                   ready;
    logic                   power_en;
    sms_method_type         method;
    logic                   mode_bad;
    logic                   seq_err;
    logic [SPD_W-1:0]       speed;
    logic                   turn_cw;
    logic                   cw_ok;
    logic                   ccw_ok;
    logic                   enc_a;
    logic                   enc_b;
  } sms_state_type;

  sms_state_type s_reg;
  sms_state_type s_next;

  logic [POS_W-1:0]  position;
  logic [RATE_W-1:0] rate;
  logic              map_cw;
  logic              map_cw_ok;
  logic              map_ccw_ok;
  logic              fwd_logical;

  // mode digit plus switch input to the method in force
  function automatic sms_method_type mode_method(input logic [3:0] mode,
                                                 input logic       alt);
    case (mode)
      MODE_SPEED:   mode_method = SMS_M_SPEED;
      MODE_POS:     mode_method = SMS_M_POS;
      MODE_TORQUE:  mode_method = SMS_M_TORQUE;
      MODE_CONTACT: mode_method = SMS_M_CONTACT;
      4'h4: mode_method = alt ? SMS_M_SPEED  : SMS_M_CONTACT;
      4'h5: mode_method = alt ? SMS_M_POS    : SMS_M_CONTACT;
      4'h6: mode_method = alt ? SMS_M_TORQUE : SMS_M_CONTACT;
      4'h7: mode_method = alt ? SMS_M_SPEED  : SMS_M_POS;
      4'h8: mode_method = alt ? SMS_M_TORQUE : SMS_M_POS;
      4'h9: mode_method = alt ? SMS_M_SPEED  : SMS_M_TORQUE;
      4'ha: mode_method = alt ? SMS_M_POS    : SMS_M_SPEED;
      4'hb: mode_method = alt ? SMS_M_TORQUE : SMS_M_SPEED;
      4'hc: mode_method = alt ? SMS_M_CONTACT : SMS_M_SPEED;
      4'hd: mode_method = alt ? SMS_M_CONTACT : SMS_M_POS;
      4'he: mode_method = alt ? SMS_M_CONTACT : SMS_M_TORQUE;
      default: mode_method = SMS_M_SPEED;
    endcase
  endfunction

  function automatic logic addr_hit(input logic [ADDR_W-1:0] a);
    addr_hit = (a == OFF_CTRL) || (a == OFF_STATUS) ||
               (a == OFF_PRESET0) || (a == OFF_PRESET0 + 8'h04) ||
               (a == OFF_PRESET0 + 8'h08) || (a == OFF_POS) ||
               (a == OFF_RATE);
  endfunction

  assign fwd_logical = (s_reg.method == SMS_M_CONTACT) ?
                       preset_select_a_n : cmd_forward;

  sms_dir_map u_dir_map
  (
    .reverse     (s_reg.dir_act),
    .cmd_forward (fwd_logical),
    .fwd_limit   (forward_limit_in),
    .rev_limit   (reverse_limit_in),
    .turn_cw     (map_cw),
    .cw_ok       (map_cw_ok),
    .ccw_ok      (map_ccw_ok)
  );

  sms_pulse_meter
  #(
    .POS_W   (POS_W),
    .RATE_W  (RATE_W),
    .WIN_CYC (RATE_WIN_CYC)
  )
  u_meter
  (
    .clk       (pclk),
    .rst_n     (presetn),
    .count_en  (s_reg.method == SMS_M_POS && s_reg.power_en),
    .pulse     (ref_pulse),
    .pulse_dir (ref_pulse_dir),
    .position  (position),
    .rate      (rate)
  );

  always_comb
  begin
    logic        setup;
    logic        wr;
    logic        en_req;
    logic [1:0]  psel_idx;
    logic [31:0] rd;
    setup    = 1'b0;
    wr       = 1'b0;
    en_req   = 1'b0;
    psel_idx = 2'b00;
    rd       = 32'h0;
    s_next   = s_reg;

    // apb: answer in the first access cycle
    setup             = apb_req.psel && !apb_req.penable;
    wr                = apb_req.psel && apb_req.penable &&
                        s_reg.rsp.pready && apb_req.pwrite &&
                        !s_reg.rsp.pslverr;
    s_next.rsp.pready = setup;
    if (!setup)
    begin
      s_next.rsp.pslverr = 1'b0;
      s_next.rsp.prdata  = 32'h0;
    end
    else
    begin
      s_next.rsp.pslverr = !addr_hit(apb_req.paddr);
      case (apb_req.paddr)
        OFF_CTRL:
        begin
          rd[CTRL_SRC_BIT]                   = s_reg.src_pend;
          rd[CTRL_DIR_BIT]                   = s_reg.dir_pend;
          rd[CTRL_MODE_LSB +: 4]             = s_reg.mode;
          rd[CTRL_PIN_LSB +: 2]              = s_reg.pin_sel;
        end
        OFF_STATUS:
        begin
          rd[11:0] = {s_reg.ccw_ok, s_reg.cw_ok, s_reg.mode_bad,
                      s_reg.seq_err, s_reg.dir_act, s_reg.src_act,
                      s_reg.method, s_reg.en_state, s_reg.power_en,
                      s_reg.ready};
        end
        OFF_PRESET0:          rd[SPD_W-1:0] = s_reg.presets[0];
        OFF_PRESET0 + 8'h04:  rd[SPD_W-1:0] = s_reg.presets[1];
        OFF_PRESET0 + 8'h08:  rd[SPD_W-1:0] = s_reg.presets[2];
        OFF_POS:              rd[POS_W-1:0] = position;
        OFF_RATE:             rd[RATE_W-1:0] = rate;
        default:              rd = 32'h0;
      endcase
      s_next.rsp.prdata = rd;
    end

    // register writes at the access edge
    if (wr)
    begin
      case (apb_req.paddr)
        OFF_CTRL:
        begin
          s_next.src_pend = apb_req.pwdata[CTRL_SRC_BIT];
          s_next.dir_pend = apb_req.pwdata[CTRL_DIR_BIT];
          s_next.mode     = apb_req.pwdata[CTRL_MODE_LSB +: 4];
          s_next.pin_sel  = apb_req.pwdata[CTRL_PIN_LSB +: 2];
        end
        OFF_STATUS:
        begin
          if (apb_req.pwdata[ST_SEQ_BIT])
          begin
            s_next.seq_err = 1'b0;
          end
        end
        OFF_PRESET0:         s_next.presets[0] = apb_req.pwdata[SPD_W-1:0];
        OFF_PRESET0 + 8'h04: s_next.presets[1] = apb_req.pwdata[SPD_W-1:0];
        OFF_PRESET0 + 8'h08: s_next.presets[2] = apb_req.pwdata[SPD_W-1:0];
        default:             s_next.mode = s_next.mode;
      endcase
    end

    // settings needing a power cycle wait for both supplies to drop
    if (!main_power_ok)
    begin
      s_next.main_down = 1'b1;
    end
    if (!ctrl_power_ok)
    begin
      s_next.ctrl_down = 1'b1;
    end
    if (s_reg.main_down && s_reg.ctrl_down && main_power_ok &&
        ctrl_power_ok)
    begin
      s_next.src_act   = s_reg.src_pend;
      s_next.dir_act   = s_reg.dir_pend;
      s_next.main_down = 1'b0;
      s_next.ctrl_down = 1'b0;
    end

    // mode decode applies at once
    s_next.method   = mode_method(s_reg.mode, mode_switch_in);
    s_next.mode_bad = (s_reg.mode == 4'hf);

    // enable sequencing
    s_next.ready = main_power_ok && ctrl_power_ok;
    psel_idx     = (32'(s_reg.pin_sel) < EN_PINS) ? s_reg.pin_sel : 2'b00;
    en_req       = s_reg.src_act ? s_reg.ready
                                 : !enable_pins_n[psel_idx];
    case (s_reg.en_state)
      SMS_EN_OFF:
      begin
        if (s_reg.ready)
        begin
          s_next.en_state = SMS_EN_READY;
        end
      end
      SMS_EN_READY:
      begin
        if (!s_reg.ready)
        begin
          s_next.en_state = SMS_EN_OFF;
        end
        else if (en_req)
        begin
          s_next.en_state = SMS_EN_RUN;
          if (ref_active)
          begin
            s_next.seq_err = 1'b1;
          end
        end
      end
      SMS_EN_RUN:
      begin
        if (!s_reg.ready)
        begin
          s_next.en_state = SMS_EN_OFF;
        end
        else if (!en_req)
        begin
          s_next.en_state = SMS_EN_READY;
          if (ref_active)
          begin
            s_next.seq_err = 1'b1;
          end
        end
      end
      default: s_next.en_state = SMS_EN_OFF;
    endcase
    s_next.power_en = (s_next.en_state == SMS_EN_RUN);

    // contact mode: b and c choose zero or one of three presets
    s_next.speed = '0;
    if (s_next.method == SMS_M_CONTACT &&
        !(preset_select_b_n && preset_select_c_n))
    begin
      s_next.speed = s_reg.presets[{~preset_select_c_n,
                                    ~preset_select_b_n} - 2'b01];
    end

    s_next.turn_cw = map_cw;
    s_next.cw_ok   = map_cw_ok;
    s_next.ccw_ok  = map_ccw_ok;
    // encoder outputs never see the direction bit
    s_next.enc_a   = encoder_a_in;
    s_next.enc_b   = encoder_b_in;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s_reg <= '0;
    end
    else
    begin
      s_reg <= s_next;
    end
  end

  assign apb_rsp             = s_reg.rsp;
  assign servo_ready         = s_reg.ready;
  assign motor_power_en      = s_reg.power_en;
  assign active_method       = s_reg.method;
  assign preset_speed        = s_reg.speed;
  assign motor_turn_cw       = s_reg.turn_cw;
  assign cw_permit           = s_reg.cw_ok;
  assign ccw_permit          = s_reg.ccw_ok;
  assign encoder_div_phase_a = s_reg.enc_a;
  assign encoder_div_phase_b = s_reg.enc_b;

endmodule

// *** tb/sms_host_model.sv ***
/*
  host motion controller model: servo enable and reference pulses.
  assumes run is held high for a whole move and n_pulses stays stable.
*/
`timescale 1ns/10ps
module sms_host_model
(
  input  logic       pclk,
  input  logic       presetn,
  input  logic       run,
  input  logic [3:0] n_pulses,
  output logic       enable_n,
  output logic       ref_active,
  output logic       ref_pulse,
  output logic       ref_pulse_dir
);
  logic [5:0] cnt;

  assign ref_pulse_dir = 1'b0;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      enable_n <= 1'b1;
      ref_active <= 1'b0;
      ref_pulse <= 1'b0;
      cnt <= 6'h00;
    end
    else if (run)
    begin
      enable_n <= 1'b0;
      cnt <= cnt + {5'h00, cnt != 6'h3f};
      ref_active <= cnt >= 6'h03;
      ref_pulse <= cnt >= 6'h05 && cnt[0] &&
                   cnt < 6'h05 + {1'b0, n_pulses, 1'b0};
    end
    else
    begin
      // reference goes away first, enable one cycle later
      ref_active <= 1'b0;
      enable_n <= enable_n | ~ref_active;
      ref_pulse <= 1'b0;
      cnt <= 6'h00;
    end
  end
endmodule

// *** tb/sms_top_monitor.sv ***
/*
  concurrent checks on the servo enable and mode select block ports.
  assumes it is bound into sms_top and sees one clock domain.
*/
`timescale 1ns/10ps
module sms_top_monitor
(
  input logic                     pclk,
  input logic                     presetn,
  input sms_pkg::sms_apb_req_type apb_req,
  input sms_pkg::sms_apb_rsp_type apb_rsp,
  input logic                     main_power_ok,
  input logic                     ctrl_power_ok,
  input logic                     forward_limit_in,
  input logic                     reverse_limit_in,
  input logic                     encoder_a_in,
  input logic                     encoder_b_in,
  input logic                     servo_ready,
  input logic                     motor_power_en,
  input sms_pkg::sms_method_type  active_method,
  input logic                     cw_permit,
  input logic                     ccw_permit,
  input logic                     encoder_div_phase_a,
  input logic                     encoder_div_phase_b
);
  import sms_pkg::*;
  logic [3:0] mode_r;

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  // mode digit as last written over the bus
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      mode_r <= 4'h0;
    else if (apb_req.psel && apb_req.penable && apb_rsp.pready &&
             apb_req.pwrite && apb_req.paddr == OFF_CTRL)
      mode_r <= apb_req.pwdata[5:2];

  a_ready_on: assert property
    (main_power_ok && ctrl_power_ok |=> servo_ready)
    else $error("servo ready missing with both supplies up");
  a_ready_off: assert property
    (!(main_power_ok && ctrl_power_ok) |=> !servo_ready)
    else $error("servo ready with a supply down");
  a_power_off: assert property (!servo_ready |=> !motor_power_en)
    else $error("motor power while not ready");
  a_power_rise: assert property
    ($rose(motor_power_en) |-> $past(servo_ready, 2))
    else $error("motor power rose without prior ready");
  a_enc_kept: assert property ($past(presetn) |->
      encoder_div_phase_a == $past(encoder_a_in) &&
      encoder_div_phase_b == $past(encoder_b_in))
    else $error("encoder division output not a plain copy");
  a_limit_both: assert property ($past(presetn) &&
      $past(forward_limit_in && reverse_limit_in) |->
      !cw_permit && !ccw_permit)
    else $error("motion permitted with both limits active");
  a_limit_one: assert property ($past(presetn) &&
      $past(forward_limit_in ^ reverse_limit_in) |->
      cw_permit ^ ccw_permit)
    else $error("one limit must block exactly one direction");
  a_mode_speed: assert property
    (mode_r == 4'h0 |=> active_method == SMS_M_SPEED)
    else $error("mode 0 not speed");
  a_mode_pos: assert property
    (mode_r == 4'h1 |=> active_method == SMS_M_POS)
    else $error("mode 1 not position");
  a_mode_contact: assert property
    (mode_r == 4'h3 |=> active_method == SMS_M_CONTACT)
    else $error("mode 3 not contact speed");
  a_apb_answer: assert property
    (apb_req.psel && !apb_req.penable |=> apb_rsp.pready)
    else $error("no answer in first access cycle");
  a_apb_refuse: assert property (apb_req.psel && !apb_req.penable &&
      apb_req.paddr == 8'h40 |=> apb_rsp.pslverr && apb_rsp.prdata == 32'h0)
    else $error("unmapped access not refused");
endmodule

// *** tb/tb.sv ***
/*
  self-checking bench for the servo enable and mode select block.
  assumes the host model drives enable pin 0; monitor bound at the foot.
*/
`timescale 1ns/10ps
module tb;
  import sms_pkg::*;
  logic             pclk = 1'b0;
  logic             presetn = 1'b1;
  sms_apb_req_type  apb_req = '0;
  sms_apb_rsp_type  apb_rsp;
  logic             main_power_ok = 1'b1;
  logic             ctrl_power_ok = 1'b1;
  logic [2:0]       pins_hi = 3'h7;
  logic             host_en_n;
  logic             ref_active;
  logic             ref_pulse;
  logic             ref_pulse_dir;
  logic             run = 1'b0;
  logic             mode_switch_in = 1'b0;
  logic             cmd_forward = 1'b1;
  logic             preset_select_a_n = 1'b1;
  logic             preset_select_b_n = 1'b1;
  logic             preset_select_c_n = 1'b1;
  logic             forward_limit_in = 1'b0;
  logic             reverse_limit_in = 1'b0;
  logic             encoder_a_in = 1'b0;
  logic             encoder_b_in = 1'b0;
  logic             servo_ready;
  logic             motor_power_en;
  sms_method_type   active_method;
  logic [SPD_W-1:0] preset_speed;
  logic             motor_turn_cw;
  logic             cw_permit;
  logic             ccw_permit;
  logic             encoder_div_phase_a;
  logic             encoder_div_phase_b;
  logic [31:0]      rdata;
  logic             rerr;
  int               num_errors = 0;
  int               checks = 0;

  sms_top #(.RATE_WIN_CYC(16)) sms_top_i
  (
    .pclk, .presetn, .apb_req, .apb_rsp, .main_power_ok, .ctrl_power_ok,
    .enable_pins_n({pins_hi, host_en_n}), .ref_active, .ref_pulse,
    .ref_pulse_dir, .mode_switch_in, .cmd_forward, .preset_select_a_n,
    .preset_select_b_n, .preset_select_c_n, .forward_limit_in,
    .reverse_limit_in, .encoder_a_in, .encoder_b_in, .servo_ready,
    .motor_power_en, .active_method, .preset_speed, .motor_turn_cw,
    .cw_permit, .ccw_permit, .encoder_div_phase_a, .encoder_div_phase_b
  );

  sms_host_model sms_host_model_i
  (
    .pclk, .presetn, .run, .n_pulses(4'h5), .enable_n(host_en_n),
    .ref_active, .ref_pulse, .ref_pulse_dir
  );

  initial
    forever #10 pclk = ~pclk;

  task automatic report_and_stop;
    if (num_errors == 0 && checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge pclk);
  endtask

  // one apb transfer; leaves an idle edge so the next call starts clean
  task automatic apb(input logic [7:0] a, input logic w,
                     input logic [31:0] d);
    int n;
    n = 0;
    apb_req.paddr <= a;
    apb_req.pwrite <= w;
    apb_req.pwdata <= d;
    apb_req.psel <= 1'b1;
    @(posedge pclk);
    apb_req.penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (apb_rsp.pready !== 1'b1 && n < 50);
    if (n >= 50)
      num_errors++;
    rdata = apb_rsp.prdata;
    rerr = apb_rsp.pslverr;
    apb_req.psel <= 1'b0;
    apb_req.penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic pwr_cycle;
    main_power_ok <= 1'b0;
    tick(2);
    ctrl_power_ok <= 1'b0;
    tick(2);
    main_power_ok <= 1'b1;
    ctrl_power_ok <= 1'b1;
    tick(4);
  endtask

  task automatic t_apb_refuse;
    apb(OFF_CTRL, 1'b0, 32'h0);
    chk("ctrl reset", 32'h0, rdata);
    apb(8'h40, 1'b1, 32'hffff_ffff);
    apb(8'h40, 1'b0, 32'h0);
    chk("unmapped err", 32'h1, {31'h0, rerr});
    chk("unmapped data", 32'h0, rdata);
  endtask

  task automatic t_pulse;
    apb(OFF_CTRL, 1'b1, 32'h4);
    run <= 1'b1;
    tick(40);
    chk("power on", 32'h1, 32'(motor_power_en));
    apb(OFF_POS, 1'b0, 32'h0);
    chk("position", 32'h5, rdata);
    run <= 1'b0;
    tick(4);
    chk("power off", 32'h0, 32'(motor_power_en));
  endtask

  task automatic t_modes;
    for (int m = 0; m < 4; m++)
    begin
      apb(OFF_CTRL, 1'b1, 32'(m) << CTRL_MODE_LSB);
      tick(2);
      chk("method", 32'(m), 32'(active_method));
    end
    apb(OFF_CTRL, 1'b1, 32'h10);
    tick(2);
    chk("mode 4 sw 0", 32'(SMS_M_CONTACT), 32'(active_method));
    mode_switch_in <= 1'b1;
    tick(3);
    chk("mode 4 sw 1", 32'(SMS_M_SPEED), 32'(active_method));
    apb(OFF_CTRL, 1'b1, 32'h38);
    tick(2);
    chk("mode e sw 1", 32'(SMS_M_CONTACT), 32'(active_method));
    apb(OFF_CTRL, 1'b1, 32'h3c);
    apb(OFF_STATUS, 1'b0, 32'h0);
    chk("mode f bad", 32'h1, 32'(rdata[9]));
    chk("mode f speed", 32'(SMS_M_SPEED), 32'(active_method));
    mode_switch_in <= 1'b0;
  endtask

  task automatic t_contact;
    logic [15:0] exp;
    for (int p = 0; p < 3; p++)
      apb(OFF_PRESET0 + 8'(4 * p), 1'b1, 32'h111 * (p + 1));
    apb(OFF_CTRL, 1'b1, 32'hc);
    for (int k = 0; k < 4; k++)
    begin
      {preset_select_c_n, preset_select_b_n} <= ~2'(k);
      tick(3);
      exp = (k == 0) ? 16'h0 : 16'(16'h111 * k);
      chk("preset speed", 32'(exp), 32'(preset_speed));
    end
    {preset_select_c_n, preset_select_b_n} <= 2'h3;
    preset_select_a_n <= 1'b0;
    tick(3);
    chk("contact reverse", 32'h1, 32'(motor_turn_cw));
    preset_select_a_n <= 1'b1;
  endtask

  task automatic t_enable;
    apb(OFF_CTRL, 1'b1, 32'h80);
    pins_hi[1] <= 1'b0;
    tick(4);
    chk("power via pin 2", 32'h1, 32'(motor_power_en));
    pins_hi[1] <= 1'b1;
    tick(4);
    chk("pin 2 released", 32'h0, 32'(motor_power_en));
    run <= 1'b1;
    tick(6);
    pins_hi[1] <= 1'b0;
    tick(3);
    apb(OFF_STATUS, 1'b0, 32'h0);
    chk("order flag set", 32'h1, 32'(rdata[8]));
    run <= 1'b0;
    tick(2);
    pins_hi[1] <= 1'b1;
    tick(3);
    apb(OFF_STATUS, 1'b1, 32'h100);
    apb(OFF_STATUS, 1'b0, 32'h0);
    chk("order flag clr", 32'h0, 32'(rdata[8]));
    apb(OFF_CTRL, 1'b1, 32'h0);
    pins_hi[1] <= 1'b0;
    tick(4);
    chk("pin 2 unselected", 32'h0, 32'(motor_power_en));
    pins_hi[1] <= 1'b1;
  endtask

  task automatic t_direction;
    apb(OFF_CTRL, 1'b1, 32'h2);
    forward_limit_in <= 1'b1;
    encoder_a_in <= 1'b1;
    tick(3);
    chk("cw before cycle", 32'h0, 32'(motor_turn_cw));
    chk("ccw gated", 32'h0, 32'(ccw_permit));
    pwr_cycle();
    chk("cw after cycle", 32'h1, 32'(motor_turn_cw));
    chk("cw gated", 32'h0, 32'(cw_permit));
    chk("ccw free", 32'h1, 32'(ccw_permit));
    chk("enc a", 32'h1, 32'(encoder_div_phase_a));
    chk("enc b", 32'h0, 32'(encoder_div_phase_b));
    reverse_limit_in <= 1'b1;
    cmd_forward <= 1'b0;
    tick(3);
    chk("both gated", 32'h0, 32'({cw_permit, ccw_permit}));
    chk("reverse ccw", 32'h0, 32'(motor_turn_cw));
    forward_limit_in <= 1'b0;
    tick(3);
    chk("rev limit swap", 32'h2, 32'({cw_permit, ccw_permit}));
    reverse_limit_in <= 1'b0;
    cmd_forward <= 1'b1;
  endtask

  task automatic t_source;
    apb(OFF_CTRL, 1'b1, 32'h1);
    tick(4);
    chk("no auto run yet", 32'h0, 32'(motor_power_en));
    pwr_cycle();
    tick(4);
    chk("auto run", 32'h1, 32'(motor_power_en));
  endtask

  initial
  begin
    presetn <= 1'b0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_apb_refuse();
    t_pulse();
    t_modes();
    t_contact();
    t_enable();
    t_direction();
    t_source();
    report_and_stop();
  end

  initial
  begin
    repeat (5000) @(posedge pclk);
    num_errors++;
    report_and_stop();
  end
endmodule

bind sms_top sms_top_monitor sms_top_monitor_i
(
  .pclk, .presetn, .apb_req, .apb_rsp, .main_power_ok, .ctrl_power_ok,
  .forward_limit_in, .reverse_limit_in, .encoder_a_in, .encoder_b_in,
  .servo_ready, .motor_power_en, .active_method, .cw_permit, .ccw_permit,
  .encoder_div_phase_a, .encoder_div_phase_b
);
